// ---- core/sector_password_protection.sv ----
// Functional notes
// - Sixteen-bit protection-mode register; only bits 2:1 active, others read one.
// - Freeze flag at zero guards all persistent lock bits against change.
// - One persistent lock bit per 128KB sector; locked until erased.
// - One temporary lock bit per 128KB sector; cleared by hard and soft reset.
// - Lock bits always cover 128KB; range protection uses 64KB steps.
// - Bit 2 one-time; zero enables password mode, hides and freezes password.
// - Bit 1 one-time; zero selects no-password mode, bit 2 stays one.
// - At most one of bits 2 and 1 ever reaches zero.
// - Host sets password first; password changes are refused once password mode is set.
// - In password mode freeze returns to one only with right password.
// - Persistent lock bits changeable in either mode, subject to freeze.
// - Factory state: all persistent lock bits unlocked.
// - Freeze register bits 7:1 read zero; bit 0 zero refuses persistent lock edits.
// - A read command returns the freeze flag.
// - Password mode: freeze comes out of every reset locked.
// - In password mode, unlock with correct password sets freeze flag to one.
// - Freeze-write command clears freeze flag to zero.
// - Persistent lock reads 00h when locked, FFh when open.
// - Persistent lock bits program singly, erase only all together.
// - Temporary lock write acts only while its lockdown bit is zero.
`timescale 1ns/1ns
`default_nettype none

module sector_password_protection import spp_pkg::*; (
	// Clock and resets
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_soft_reset,
	input wire logic i_factory_init,
	// Command link
	input wire logic i_link_clk,
	input wire logic i_link_cs_n,
	input wire logic [7:0] i_link_dq,
	output logic [7:0] o_link_dq,
	output logic o_link_dq_oe,
	// Range protection from the block protect decoder
	input wire logic i_bp_en,
	input wire logic [BP_W-1:0] i_bp_lo_64k,
	input wire logic [BP_W-1:0] i_bp_hi_64k,
	// Array operation verdicts
	output logic o_array_grant,
	output logic o_array_refuse,
	output logic [31:0] o_array_addr,
	// Status
	output logic [15:0] o_prot_mode,
	output logic o_freeze
);

	// Commands that carry a four-byte address
	function automatic logic has_addr(input logic [7:0] c);
		has_addr = (c == CMD_RD_NVL) || (c == CMD_WR_NVL) ||
			(c == CMD_RD_VL) || (c == CMD_WR_VL) ||
			(c == CMD_PROG) || (c == CMD_ERASE);
	endfunction

	link_bus_if lb();

	link_shifter u_shift (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_link_clk(i_link_clk),
		.i_link_cs_n(i_link_cs_n),
		.i_link_dq(i_link_dq),
		.o_link_dq(o_link_dq),
		.o_link_dq_oe(o_link_dq_oe),
		.bus(lb.shifter)
	);

	// Nonvolatile state
	logic [2:1] pmr_reg, pmr_next;
	logic [63:0] pw_reg, pw_next;
	logic [SECTORS-1:0] nvl_reg, nvl_next;
	// Volatile state
	cmd_state_t state_reg, state_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [31:0] addr_reg, addr_next;
	logic [63:0] data_reg, data_next;
	logic frz_reg, frz_next;
	logic init_reg, init_next;
	logic [SECTORS-1:0] vwp_reg, vwp_next;
	logic [SECTORS-1:0] vld_reg, vld_next;
	logic grant_reg, grant_next;
	logic refuse_reg, refuse_next;
	logic [31:0] arr_addr_reg, arr_addr_next;

	logic pw_mode;
	logic [SEC_W-1:0] sec;
	logic [BP_W-1:0] blk64;
	logic bp_hit;
	logic sec_prot;
	logic exec;
	logic [3:0] idx;
	logic [2:1] pmr_try;
	logic pw_match;
	logic unlock_ok;

	// Sector lock index is 128KB, range check is 64KB
	assign sec = addr_reg[SEC_LSB +: SEC_W];
	assign blk64 = addr_reg[BP_LSB +: BP_W];
	assign bp_hit = i_bp_en && (blk64 >= i_bp_lo_64k) &&
		(blk64 <= i_bp_hi_64k);
	assign sec_prot = ~nvl_reg[sec] | vwp_reg[sec] | bp_hit;
	assign pw_mode = ~pmr_reg[PMR_PW_BIT];
	assign exec = lb.frame_end && (state_reg == ST_BODY);
	assign idx = has_addr(cmd_reg) ? cnt_reg - ADDR_BYTES : cnt_reg;
	assign pmr_try = pmr_reg & data_reg[2:1];
	assign pw_match = (data_reg == pw_reg);
	assign unlock_ok = exec && (cmd_reg == CMD_UNLOCK) &&
		(cnt_reg == PW_BYTES) && pw_mode && pw_match;

	// Read data presented on the link
	always_comb begin
		lb.tx_byte = 8'h00;
		lb.tx_en = 1'b0;
		if (state_reg == ST_BODY && (!has_addr(cmd_reg) ||
			cnt_reg >= ADDR_BYTES)) begin
			lb.tx_en = 1'b1;
			case (cmd_reg)
			CMD_RD_PMR: begin
				lb.tx_byte = (idx == 4'h0) ? o_prot_mode[15:8] :
					o_prot_mode[7:0];
			end
			CMD_RD_FRZ: begin
				lb.tx_byte = {FRZ_RSVD, frz_reg};
			end
			CMD_RD_PW: begin
				lb.tx_byte = pw_mode ? PW_HIDDEN :
					pw_reg[8*(7-idx[2:0]) +: 8];
			end
			CMD_RD_NVL: begin
				lb.tx_byte = nvl_reg[sec] ? NVL_OPEN : NVL_LOCKED;
			end
			CMD_RD_VL: begin
				lb.tx_byte = {VL_RSVD, vld_reg[sec], vwp_reg[sec]};
			end
			default: begin
				lb.tx_en = 1'b0;
			end
			endcase
		end
	end

	// Nonvolatile next values, applied at frame end
	always_comb begin
		pmr_next = pmr_reg;
		pw_next = pw_reg;
		nvl_next = nvl_reg;
		if (exec) begin
			case (cmd_reg)
			CMD_WR_PMR: begin
				// Only one-to-zero, never both zero
				if (cnt_reg == PMR_BYTES && pmr_try != 2'h0) begin
					pmr_next = pmr_try;
				end
			end
			CMD_WR_PW: begin
				if (cnt_reg == PW_BYTES && !pw_mode) begin
					pw_next = data_reg;
				end
			end
			CMD_WR_NVL: begin
				// Mode bit 1 plays no part here
				if (cnt_reg == ADDR_BYTES && frz_reg) begin
					nvl_next[sec] = 1'b0;
				end
			end
			CMD_ER_NVL: begin
				if (cnt_reg == NO_BYTES && frz_reg) begin
					nvl_next = '1;
				end
			end
			default: begin
			end
			endcase
		end
	end

	// Nonvolatile registers, blank only at factory initialisation
	always_ff @(posedge i_ref_clk or posedge i_factory_init) begin
		if (i_factory_init) begin
			pmr_reg <= PMR_ACTIVE_RESET;
			pw_reg <= PW_RESET;
			nvl_reg <= '1;
		end else begin
			pmr_reg <= pmr_next;
			pw_reg <= pw_next;
			nvl_reg <= nvl_next;
		end
	end

	// Decoder, freeze flag and temporary locks
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		frz_next = frz_reg;
		init_next = 1'b1;
		vwp_next = vwp_reg;
		vld_next = vld_reg;
		grant_next = 1'b0;
		refuse_next = 1'b0;
		arr_addr_next = arr_addr_reg;
		if (lb.byte_stb) begin
			if (state_reg == ST_WAIT_CMD) begin
				state_next = ST_BODY;
				cmd_next = lb.byte_data;
				cnt_next = 4'h0;
			end else begin
				if (has_addr(cmd_reg) && cnt_reg < ADDR_BYTES) begin
					addr_next = {addr_reg[23:0], lb.byte_data};
				end else begin
					data_next = {data_reg[55:0], lb.byte_data};
				end
				if (cnt_reg != CNT_MAX) begin
					cnt_next = cnt_reg + 4'h1;
				end
			end
		end
		if (lb.frame_end) begin
			state_next = ST_WAIT_CMD;
		end
		if (exec) begin
			case (cmd_reg)
			CMD_WR_FRZ: begin
				if (cnt_reg == NO_BYTES) begin
					frz_next = 1'b0;
				end
			end
			CMD_UNLOCK: begin
				if (unlock_ok) begin
					frz_next = 1'b1;
				end
			end
			CMD_WR_VL: begin
				if (cnt_reg == VL_WR_BYTES && !vld_reg[sec]) begin
					vwp_next[sec] = data_reg[VL_WP_BIT];
					vld_next[sec] = data_reg[VL_LD_BIT];
				end
			end
			CMD_PROG, CMD_ERASE: begin
				if (cnt_reg == ADDR_BYTES) begin
					grant_next = ~sec_prot;
					refuse_next = sec_prot;
					arr_addr_next = addr_reg;
				end
			end
			default: begin
			end
			endcase
		end
		// Reset behaviour of volatile protection
		if (i_soft_reset || !init_reg) begin
			frz_next = ~pw_mode;
			vwp_next = '0;
			vld_next = '0;
		end
	end

	// Volatile registers
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_WAIT_CMD;
			cmd_reg <= 8'h00;
			cnt_reg <= 4'h0;
			addr_reg <= 32'h0000_0000;
			data_reg <= 64'h0000_0000_0000_0000;
			frz_reg <= FRZ_RESET;
			init_reg <= 1'b0;
			vwp_reg <= '0;
			vld_reg <= '0;
			grant_reg <= 1'b0;
			refuse_reg <= 1'b0;
			arr_addr_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			frz_reg <= frz_next;
			init_reg <= init_next;
			vwp_reg <= vwp_next;
			vld_reg <= vld_next;
			grant_reg <= grant_next;
			refuse_reg <= refuse_next;
			arr_addr_reg <= arr_addr_next;
		end
	end

	// Outputs
	assign o_prot_mode = {PMR_RSVD_HI, pmr_reg, PMR_RSVD_LO};
	assign o_freeze = frz_reg;
	assign o_array_grant = grant_reg;
	assign o_array_refuse = refuse_reg;
	assign o_array_addr = arr_addr_reg;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst || i_factory_init);

	property p_pmr_reserved;
		o_prot_mode[15:3] == PMR_RSVD_HI && o_prot_mode[0] == PMR_RSVD_LO;
	endproperty
	a_pmr_reserved: assert property (p_pmr_reserved)
		else $error("reserved mode bits not one");

	property p_mode_exclusive;
		pmr_reg != 2'h0;
	endproperty
	a_mode_exclusive: assert property (p_mode_exclusive)
		else $error("both mode bits programmed");

	property p_frozen_stable;
		!frz_reg |=> $stable(nvl_reg);
	endproperty
	a_frozen_stable: assert property (p_frozen_stable)
		else $error("lock bits changed while frozen");

	property p_soft_clear;
		i_soft_reset |=> vwp_reg == '0 && vld_reg == '0;
	endproperty
	a_soft_clear: assert property (p_soft_clear)
		else $error("temporary locks survived reset");

	property p_pw_fixed;
		pw_mode |=> $stable(pw_reg);
	endproperty
	a_pw_fixed: assert property (p_pw_fixed)
		else $error("password changed in password mode");

	property p_unlock_only;
		pw_mode && !frz_reg && !i_soft_reset && init_reg ##1 frz_reg
			|-> $past(unlock_ok);
	endproperty
	a_unlock_only: assert property (p_unlock_only)
		else $error("freeze released without password");

	property p_freeze_write;
		exec && cmd_reg == CMD_WR_FRZ && cnt_reg == NO_BYTES &&
			!i_soft_reset |=> !frz_reg;
	endproperty
	a_freeze_write: assert property (p_freeze_write)
		else $error("freeze write did not clear flag");

	property p_refuse;
		exec && (cmd_reg == CMD_PROG || cmd_reg == CMD_ERASE) &&
			cnt_reg == ADDR_BYTES && sec_prot
			|=> o_array_refuse && !o_array_grant ##1 !o_array_refuse;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("protected sector not refused");

	property p_lockdown;
		!i_soft_reset && init_reg |=>
			($past(vld_reg) & (vld_reg ^ $past(vld_reg))) == '0 &&
			($past(vld_reg) & (vwp_reg ^ $past(vwp_reg))) == '0;
	endproperty
	a_lockdown: assert property (p_lockdown)
		else $error("locked-down sector changed");

	property p_reset_frozen;
		!init_reg && pw_mode |=> !frz_reg;
	endproperty
	a_reset_frozen: assert property (p_reset_frozen)
		else $error("freeze not locked after reset");

	c_unlock: cover property (unlock_ok);
	c_refuse: cover property (o_array_refuse);
	c_grant: cover property (o_array_grant);
	c_vl_write: cover property (exec && cmd_reg == CMD_WR_VL);

endmodule

`default_nettype wire

// ---- include/spp_pkg.sv ----
package spp_pkg;

	// Array geometry and lock granularity
	localparam int SECTORS = 256;
	localparam int SEC_W = 8;
	localparam int SEC_LSB = 17;
	localparam int BP_LSB = 16;
	localparam int BP_W = 9;

	// Frame layout in bytes after the command byte
	localparam logic [3:0] ADDR_BYTES = 4'h4;
	localparam logic [3:0] PMR_BYTES = 4'h2;
	localparam logic [3:0] PW_BYTES = 4'h8;
	localparam logic [3:0] VL_WR_BYTES = 4'h5;
	localparam logic [3:0] NO_BYTES = 4'h0;
	localparam logic [3:0] CNT_MAX = 4'hf;

	// Protection-mode register: active bits [2:1], the rest read as one
	localparam logic [2:1] PMR_ACTIVE_RESET = 2'h3;
	localparam logic [12:0] PMR_RSVD_HI = 13'h1fff;
	localparam logic PMR_RSVD_LO = 1'h1;
	localparam int PMR_PW_BIT = 2;
	localparam int PMR_SP_BIT = 1;

	// Password, freeze flag and lock byte encodings
	localparam logic [63:0] PW_RESET = 64'hffff_ffff_ffff_ffff;
	localparam logic FRZ_RESET = 1'h1;
	localparam logic [6:0] FRZ_RSVD = 7'h00;
	localparam logic [7:0] NVL_LOCKED = 8'h00;
	localparam logic [7:0] NVL_OPEN = 8'hff;
	localparam logic [7:0] PW_HIDDEN = 8'hff;
	localparam logic [5:0] VL_RSVD = 6'h00;
	localparam int VL_WP_BIT = 0;
	localparam int VL_LD_BIT = 1;

	// Command codes
	localparam logic [7:0] CMD_RD_PMR = 8'h2d;
	localparam logic [7:0] CMD_WR_PMR = 8'h2c;
	localparam logic [7:0] CMD_RD_FRZ = 8'ha7;
	localparam logic [7:0] CMD_WR_FRZ = 8'ha6;
	localparam logic [7:0] CMD_UNLOCK = 8'he9;
	localparam logic [7:0] CMD_RD_PW = 8'he7;
	localparam logic [7:0] CMD_WR_PW = 8'he8;
	localparam logic [7:0] CMD_RD_NVL = 8'he2;
	localparam logic [7:0] CMD_WR_NVL = 8'he3;
	localparam logic [7:0] CMD_ER_NVL = 8'he4;
	localparam logic [7:0] CMD_RD_VL = 8'he0;
	localparam logic [7:0] CMD_WR_VL = 8'he1;
	localparam logic [7:0] CMD_PROG = 8'h02;
	localparam logic [7:0] CMD_ERASE = 8'hdc;

	// Command decoder states
	typedef enum logic [0:0] {
		ST_WAIT_CMD = 1'b0,
		ST_BODY = 1'b1
	} cmd_state_t;

endpackage

// ---- include/link_bus_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// Byte stream between the link front end and the command core
interface link_bus_if;
	logic byte_stb;
	logic [7:0] byte_data;
	logic frame_end;
	logic [7:0] tx_byte;
	logic tx_en;

	modport shifter(output byte_stb, output byte_data, output frame_end,
		input tx_byte, input tx_en);
	modport core(input byte_stb, input byte_data, input frame_end,
		output tx_byte, output tx_en);
endinterface

`default_nettype wire

// ---- core/link_shifter.sv ----
`timescale 1ns/1ns
`default_nettype none

module link_shifter (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Link pins
	input wire logic i_link_clk,
	input wire logic i_link_cs_n,
	input wire logic [7:0] i_link_dq,
	output logic [7:0] o_link_dq,
	output logic o_link_dq_oe,
	// Byte stream to the core
	link_bus_if.shifter bus
);

	logic [9:0] sync1_reg, sync1_next;
	logic [9:0] sync2_reg, sync2_next;
	logic clk_d_reg, clk_d_next;
	logic cs_d_reg, cs_d_next;
	logic [7:0] dq_reg, dq_next;
	logic oe_reg, oe_next;
	logic rise;
	logic fall;
	logic active;

	// Edges of the sampled link clock, frame from sampled select
	assign rise = sync2_reg[9] & ~clk_d_reg;
	assign fall = ~sync2_reg[9] & clk_d_reg;
	assign active = ~sync2_reg[8];

	// Two-stage sampling, then output byte launched on falling edges
	always_comb begin
		sync1_next = {i_link_clk, i_link_cs_n, i_link_dq};
		sync2_next = sync1_reg;
		clk_d_next = sync2_reg[9];
		cs_d_next = sync2_reg[8];
		dq_next = dq_reg;
		oe_next = oe_reg;
		if (!active) begin
			oe_next = 1'b0;
		end else if (fall) begin
			dq_next = bus.tx_byte;
			oe_next = bus.tx_en;
		end
	end

	// Registers of the front end
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			// Link clock idles low, select idles high: no false edge
			sync1_reg <= 10'h100;
			sync2_reg <= 10'h100;
			clk_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
			dq_reg <= 8'h00;
			oe_reg <= 1'b0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			clk_d_reg <= clk_d_next;
			cs_d_reg <= cs_d_next;
			dq_reg <= dq_next;
			oe_reg <= oe_next;
		end
	end

	// Stream outputs
	assign bus.byte_stb = rise & active;
	assign bus.byte_data = sync2_reg[7:0];
	assign bus.frame_end = sync2_reg[8] & ~cs_d_reg;
	assign o_link_dq = dq_reg;
	assign o_link_dq_oe = oe_reg;

endmodule

`default_nettype wire

// ---- bench/host_link_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Host controller side of the link; link clock idles low between frames
module host_link_model (
	// Clock
	input wire logic i_ref_clk,
	// Link pins
	input wire logic [7:0] i_dq,
	output logic o_clk,
	output logic o_cs_n,
	output logic [7:0] o_dq
);
	logic [7:0] rd_q[$];

	// Idle levels before the first frame
	initial begin
		o_clk = 1'b0;
		o_cs_n = 1'b1;
		o_dq = 8'h00;
	end

	// Half of a 48 ns link period
	task automatic half();
		repeat (6) @(negedge i_ref_clk);
	endtask

	// Bytes out before each rise, then n_rd bytes taken at rises
	task automatic frame(input logic [7:0] tx[$], input int n_rd);
		rd_q.delete();
		@(negedge i_ref_clk);
		o_cs_n = 1'b0;
		foreach (tx[k]) begin
			o_dq = tx[k];
			half();
			o_clk = 1'b1;
			half();
			o_clk = 1'b0;
		end
		o_dq = ~o_dq; // Last byte inverted, so no stale byte stays
		repeat (n_rd) begin
			half();
			o_clk = 1'b1;
			rd_q.push_back(i_dq);
			half();
			o_clk = 1'b0;
		end
		half();
		o_cs_n = 1'b1;
		repeat (24) @(negedge i_ref_clk); // Gap above one link period
	endtask
endmodule

`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_top import spp_pkg::*; ;
	logic i_ref_clk, i_rst, i_soft_reset, i_factory_init;
	logic link_clk, link_cs_n, dq_oe, bp_en, grant, refuse, freeze;
	logic g_seen, r_seen, o_seen;
	logic [7:0] link_dq, dev_dq;
	logic [BP_W-1:0] bp_lo, bp_hi;
	logic [31:0] arr_addr;
	logic [15:0] prot_mode;
	logic [7:0] nil[$];
	logic [7:0] pw[$];
	int err_total, comparisons, cyc;

	sector_password_protection i_sector_password_protection (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_soft_reset(i_soft_reset),
		.i_factory_init(i_factory_init), .i_link_clk(link_clk),
		.i_link_cs_n(link_cs_n), .i_link_dq(link_dq), .o_link_dq(dev_dq),
		.o_link_dq_oe(dq_oe), .i_bp_en(bp_en), .i_bp_lo_64k(bp_lo),
		.i_bp_hi_64k(bp_hi), .o_array_grant(grant), .o_array_refuse(refuse),
		.o_array_addr(arr_addr), .o_prot_mode(prot_mode), .o_freeze(freeze));

	host_link_model i_host_link_model (.i_ref_clk(i_ref_clk), .i_dq(dev_dq),
		.o_clk(link_clk), .o_cs_n(link_cs_n), .o_dq(link_dq));

	// Clock, cycle count and timeout
	initial i_ref_clk = 1'b0;
	always #2 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total = err_total + 1;
			close_out();
		end
	end

	// Sticky capture of the one-cycle verdict pulses and of link output enable
	always @(posedge i_ref_clk) begin
		if (grant === 1'b1) g_seen <= 1'b1;
		if (refuse === 1'b1) r_seen <= 1'b1;
		if (dq_oe === 1'b1) o_seen <= 1'b1;
	end

	task automatic close_out();
		if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] sec(input int s);
		return 32'(s) << SEC_LSB;
	endfunction

	function automatic logic [15:0] q(input int k);
		return {8'h00, i_host_link_model.rd_q[k]};
	endfunction

	task automatic fa(input logic [7:0] c, input logic [31:0] a,
		input logic [7:0] d[$], input int n);
		i_host_link_model.frame({c, a[31:24], a[23:16], a[15:8], a[7:0], d}, n);
	endtask

	task automatic pulse_rst(input logic factory);
		@(negedge i_ref_clk);
		i_rst = 1'b1;
		i_factory_init = factory;
		repeat (6) @(negedge i_ref_clk);
		i_rst = 1'b0;
		i_factory_init = 1'b0;
		repeat (3) @(negedge i_ref_clk);
	endtask

	task automatic prog(input logic [31:0] a, input logic ok);
		g_seen = 1'b0;
		r_seen = 1'b0;
		fa(CMD_PROG, a, nil, 0);
		chk("verdict", {14'h0, !ok, ok}, {14'h0, r_seen, g_seen});
		chk("verdict addr", a[15:0], arr_addr[15:0]);
		chk("verdict addr hi", a[31:16], arr_addr[31:16]);
	endtask

	task automatic t_defaults();
		i_host_link_model.frame({CMD_RD_PMR}, 2);
		chk("pmr", {PMR_RSVD_HI, PMR_ACTIVE_RESET, PMR_RSVD_LO},
			(q(0) << 8) | q(1));
		chk("mode port", {PMR_RSVD_HI, 2'h3, PMR_RSVD_LO}, prot_mode);
		chk("oe idle", 16'h0, {15'h0, dq_oe});
		o_seen = 1'b0;
		i_host_link_model.frame({CMD_RD_FRZ}, 1);
		chk("frz", {8'h00, FRZ_RSVD, FRZ_RESET}, q(0));
		chk("oe read", 16'h1, {15'h0, o_seen});
		fa(CMD_RD_NVL, sec(9), nil, 1);
		chk("nvl", {8'h00, NVL_OPEN}, q(0));
	endtask

	task automatic t_nvl();
		fa(CMD_WR_NVL, sec(3), nil, 0);
		fa(CMD_RD_NVL, sec(3), nil, 1);
		chk("nvl3", {8'h00, NVL_LOCKED}, q(0));
		fa(CMD_RD_NVL, sec(4), nil, 1);
		chk("nvl4", {8'h00, NVL_OPEN}, q(0));
		prog(sec(3), 1'b0);
		prog(sec(4), 1'b1);
		i_host_link_model.frame({CMD_WR_FRZ}, 0);
		chk("freeze port", 16'h0, {15'h0, freeze});
		i_host_link_model.frame({CMD_RD_FRZ}, 1);
		chk("frz rd", {8'h00, FRZ_RSVD, 1'b0}, q(0));
		i_host_link_model.frame({CMD_ER_NVL}, 0);
		fa(CMD_WR_NVL, sec(5), nil, 0);
		fa(CMD_RD_NVL, sec(3), nil, 1);
		chk("frozen erase", {8'h00, NVL_LOCKED}, q(0));
		fa(CMD_RD_NVL, sec(5), nil, 1);
		chk("frozen prog", {8'h00, NVL_OPEN}, q(0));
		@(negedge i_ref_clk);
		i_soft_reset = 1'b1;
		@(negedge i_ref_clk);
		i_soft_reset = 1'b0;
		repeat (3) @(negedge i_ref_clk);
		chk("freeze soft", 16'h1, {15'h0, freeze});
		i_host_link_model.frame({CMD_ER_NVL}, 0);
		fa(CMD_RD_NVL, sec(3), nil, 1);
		chk("erase all", {8'h00, NVL_OPEN}, q(0));
	endtask

	task automatic t_vl();
		fa(CMD_WR_VL, sec(7), {8'h01}, 0);
		fa(CMD_RD_VL, sec(7), nil, 1);
		chk("vl wp", 16'h0001, q(0));
		prog(sec(7), 1'b0);
		fa(CMD_WR_VL, sec(7), {8'h03}, 0);
		fa(CMD_WR_VL, sec(7), {8'h00}, 0);
		fa(CMD_RD_VL, sec(7), nil, 1);
		chk("vl lockdown", 16'h0003, q(0));
		pulse_rst(1'b0);
		fa(CMD_RD_VL, sec(7), nil, 1);
		chk("vl reset", 16'h0000, q(0));
		prog(sec(7), 1'b1);
	endtask

	task automatic t_bp();
		bp_lo = 9'h015;
		bp_hi = 9'h015;
		bp_en = 1'b1;
		prog(32'h0015_0000, 1'b0);
		prog(sec(10), 1'b1);
		bp_en = 1'b0;
		prog(32'h0015_0000, 1'b1);
	endtask

	task automatic t_nopw();
		pulse_rst(1'b1);
		i_host_link_model.frame({CMD_WR_PMR, 8'hff, 8'hfd}, 0);
		i_host_link_model.frame({CMD_WR_PMR, 8'hff, 8'hfb}, 0);
		chk("no pw mode", {PMR_RSVD_HI, 2'h2, PMR_RSVD_LO}, prot_mode);
		fa(CMD_WR_NVL, sec(2), nil, 0);
		fa(CMD_RD_NVL, sec(2), nil, 1);
		chk("nvl no pw", {8'h00, NVL_LOCKED}, q(0));
	endtask

	task automatic t_pw();
		pulse_rst(1'b1);
		pw = {8'h3c, 8'h5a, 8'h96, 8'h0f, 8'hc3, 8'h81, 8'h42, 8'h7e};
		i_host_link_model.frame({CMD_WR_PW, pw}, 0);
		i_host_link_model.frame({CMD_RD_PW}, 8);
		foreach (pw[k]) chk("pw rd", {8'h00, pw[k]}, q(k));
		i_host_link_model.frame({CMD_WR_PMR, 8'hff, 8'hfb}, 0);
		i_host_link_model.frame({CMD_WR_PMR, 8'hff, 8'hfd}, 0);
		chk("pw mode", {PMR_RSVD_HI, 2'h1, PMR_RSVD_LO}, prot_mode);
		i_host_link_model.frame({CMD_RD_PW}, 8);
		foreach (pw[k]) chk("pw hidden", {8'h00, PW_HIDDEN}, q(k));
		pulse_rst(1'b0);
		chk("frz pw reset", 16'h0, {15'h0, freeze});
		i_host_link_model.frame({CMD_UNLOCK, 8'h00, pw[1:7]}, 0);
		chk("frz wrong pw", 16'h0, {15'h0, freeze});
		i_host_link_model.frame({CMD_UNLOCK, pw}, 0);
		chk("frz unlock", 16'h1, {15'h0, freeze});
		fa(CMD_WR_NVL, sec(6), nil, 0);
		fa(CMD_RD_NVL, sec(6), nil, 1);
		chk("nvl pw", {8'h00, NVL_LOCKED}, q(0));
	endtask

	// Main sequence
	initial begin
		err_total = 0;
		comparisons = 0;
		cyc = 0;
		i_rst = 1'b1;
		i_factory_init = 1'b1;
		i_soft_reset = 1'b0;
		bp_en = 1'b0;
		bp_lo = 9'h000;
		bp_hi = 9'h000;
		g_seen = 1'b0;
		r_seen = 1'b0;
		repeat (6) @(negedge i_ref_clk);
		i_rst = 1'b0;
		i_factory_init = 1'b0;
		repeat (3) @(negedge i_ref_clk);
		t_defaults();
		t_nvl();
		t_vl();
		t_bp();
		t_nopw();
		t_pw();
		close_out();
	end
endmodule

`default_nettype wire
